// ---- hdl/store_sequencer.sv ----
/*
  Per-loop save sequencer: a rising store request starts a
  non-volatile write; completion raises the done flag until the
  request falls.  Assumes same-clock inputs from the top.
*/
`timescale 1ns/100ps
module store_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // flag carrier
  loop_flags_if.seq lf
);

  typedef struct packed {
    loop_status_pkg::store_state_e st;
    logic req_d;
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  // next state; a request drop cancels done at the next clock edge
  always_comb begin
    s_nxt = s_r;
    s_nxt.req_d = lf.store_request_bit;
    case (s_r.st)
      loop_status_pkg::ST_IDLE: begin
        if (lf.store_request_bit && !s_r.req_d) begin
          s_nxt.st = loop_status_pkg::ST_BUSY;
        end
      end
      loop_status_pkg::ST_BUSY: begin
        // a request dropped mid-write leaves the flag low
        if (lf.store_write_done && lf.store_request_bit) begin
          s_nxt.st = loop_status_pkg::ST_DONE;
        end else if (lf.store_write_done) begin
          s_nxt.st = loop_status_pkg::ST_IDLE;
        end
      end
      loop_status_pkg::ST_DONE: begin
        if (!lf.store_request_bit) begin
          s_nxt.st = loop_status_pkg::ST_IDLE;
        end
      end
      default: s_nxt.st = loop_status_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // write strobe lasts one cycle; the memory latches it
  assign lf.store_write_start = (s_r.st == loop_status_pkg::ST_IDLE) &&
                                lf.store_request_bit && !s_r.req_d;
  assign lf.store_done_flag = (s_r.st == loop_status_pkg::ST_DONE);

  store_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == loop_status_pkg::ST_BUSY) && lf.store_write_done && lf.store_request_bit |=>
      lf.store_done_flag)
    else $error("store done not raised after write");

endmodule

// ---- hdl/temp_loop_status_flags.sv ----
/*
  Two-loop temperature control status bank: gathers each loop's
  condition inputs into a registered 16-bit status word, with each
  flag also on its own output.  Assumes the condition inputs come
  from same-clock control logic, except the raw sensor fault pins,
  which are asynchronous and synchronised here.
*/
`timescale 1ns/100ps
module temp_loop_status_flags #(
  parameter int unsigned NUM_LOOPS = loop_status_pkg::NUM_LOOPS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host refresh and commands
  input wire logic io_refresh,
  input wire logic [NUM_LOOPS-1:0] store_request_bit,
  input wire logic [NUM_LOOPS-1:0] change_gains_cmd,
  input wire logic [NUM_LOOPS-1:0] host_gains_valid,
  // measurements and settings per loop
  input wire logic [NUM_LOOPS*16-1:0] temp_meas,
  input wire logic [NUM_LOOPS*16-1:0] alarm1_lo,
  input wire logic [NUM_LOOPS*16-1:0] alarm1_hi,
  input wire logic [NUM_LOOPS*16-1:0] alarm2_lo,
  input wire logic [NUM_LOOPS*16-1:0] alarm2_hi,
  input wire logic [NUM_LOOPS*16-1:0] heater_current,
  input wire logic [NUM_LOOPS*16-1:0] burnout_threshold,
  // control state per loop
  input wire logic [NUM_LOOPS-1:0] autotuning,
  input wire logic [NUM_LOOPS-1:0] autotune_gains_update,
  input wire logic [NUM_LOOPS-1:0] control_output,
  input wire logic [NUM_LOOPS-1:0] control_stopped,
  input wire logic [NUM_LOOPS-1:0] setting_invalid,
  input wire logic [NUM_LOOPS-1:0] store_write_done,
  // asynchronous fault pins
  input wire logic [NUM_LOOPS-1:0] cold_junction_fault_pin,
  input wire logic [NUM_LOOPS-1:0] sensor_open_pin,
  input wire logic [NUM_LOOPS-1:0] input_over_range_pin,
  // status words and separate flags
  output logic [NUM_LOOPS*16-1:0] loop_status_word,
  output logic [NUM_LOOPS-1:0] first_alarm_flag,
  output logic [NUM_LOOPS-1:0] second_alarm_flag,
  output logic [NUM_LOOPS-1:0] heater_burnout_flag,
  output logic [NUM_LOOPS-1:0] autotune_running_flag,
  output logic [NUM_LOOPS-1:0] output_on_flag,
  output logic [NUM_LOOPS-1:0] control_halted_flag,
  output logic [NUM_LOOPS-1:0] invalid_setting_flag,
  output logic [NUM_LOOPS-1:0] tuned_gains_ready_flag,
  output logic [NUM_LOOPS-1:0] awaiting_refresh_flag,
  output logic [NUM_LOOPS-1:0] cold_junction_fault_flag,
  output logic [NUM_LOOPS-1:0] heater_current_overrange_flag,
  output logic [NUM_LOOPS-1:0] input_sensor_fault_flag,
  output logic [NUM_LOOPS-1:0] store_done_flag,
  // host gain transfer and memory write strobe
  output logic [NUM_LOOPS-1:0] host_gains_load,
  output logic [NUM_LOOPS-1:0] store_write_start
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2*NUM_LOOPS-1:0] sync1;
    logic [2*NUM_LOOPS-1:0] sync2;
    logic standby;
    logic [NUM_LOOPS-1:0] gains;
    logic [NUM_LOOPS-1:0] chg_d;
    logic [NUM_LOOPS*16-1:0] word;
  } bank_s;

  bank_s s_r;
  bank_s s_nxt;

  // cold junction sync, sequencer done flags and the live word
  logic [NUM_LOOPS-1:0] cj_sync1_r;
  logic [NUM_LOOPS-1:0] cj_sync2_r;
  logic [NUM_LOOPS-1:0] done_w;
  logic [NUM_LOOPS*16-1:0] word_w;

  // ------------------------------------------------------------
  // cold junction synchroniser
  // ------------------------------------------------------------
  // two flops; first stage read by the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cj_sync1_r <= '0;
      cj_sync2_r <= '0;
    end else begin
      cj_sync1_r <= cold_junction_fault_pin;
      cj_sync2_r <= cj_sync1_r;
    end
  end

  // ------------------------------------------------------------
  // per-loop flag assembly
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
      loop_flags_if lf ();
      logic [15:0] t;
      logic [15:0] cur;
      logic [15:0] w;

      assign lf.store_request_bit = store_request_bit[g];
      assign lf.store_write_done = store_write_done[g];
      assign done_w[g] = lf.store_done_flag;
      assign store_write_start[g] = lf.store_write_start;

      store_sequencer u_seq (
        .clk(clk),
        .rst_n(rst_n),
        .lf(lf)
      );

      assign t = temp_meas[g*16 +: 16];
      assign cur = heater_current[g*16 +: 16];

      // word bits from live conditions
      always_comb begin
        w = '0;
        w[loop_status_pkg::BIT_ALARM1] = (t >= alarm1_lo[g*16 +: 16]) &&
                                         (t <= alarm1_hi[g*16 +: 16]);
        w[loop_status_pkg::BIT_ALARM2] = (t >= alarm2_lo[g*16 +: 16]) &&
                                         (t <= alarm2_hi[g*16 +: 16]);
        w[loop_status_pkg::BIT_BURNOUT] = !(cur > burnout_threshold[g*16 +: 16]);
        w[loop_status_pkg::BIT_AUTOTUNE] = autotuning[g];
        w[loop_status_pkg::BIT_OUTPUT] = control_output[g];
        w[loop_status_pkg::BIT_HALTED] = control_stopped[g];
        w[loop_status_pkg::BIT_BADSET] = setting_invalid[g];
        w[loop_status_pkg::BIT_GAINS] = s_r.gains[g];
        w[loop_status_pkg::BIT_STANDBY] = s_r.standby;
        w[loop_status_pkg::BIT_CJ_FAULT] = cj_sync2_r[g];
        w[loop_status_pkg::BIT_CT_OVER] = cur > loop_status_pkg::CT_LIMIT_DA;
        w[loop_status_pkg::BIT_SENSOR] = s_r.sync2[g] | s_r.sync2[NUM_LOOPS+g];
        w[loop_status_pkg::BIT_STORED] = done_w[g];
      end

      assign word_w[g*16 +: 16] = w;
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // sensor sync, standby, gains-ready and word capture
  always_comb begin
    s_nxt = s_r;
    // each sensor pin synced alone; an or ahead of the flops could glitch
    s_nxt.sync1 = {input_over_range_pin, sensor_open_pin};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.chg_d = change_gains_cmd;
    if (io_refresh) begin
      s_nxt.standby = 1'b0;
    end
    // update sets gains ready; set wins over clear
    s_nxt.gains = (s_r.gains & ~(change_gains_cmd & ~s_r.chg_d)) |
                  autotune_gains_update;
    s_nxt.word = word_w;
  end

  // single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{sync1: '0, sync2: '0, standby: loop_status_pkg::STANDBY_RST,
               gains: '0, chg_d: '0,
               word: {NUM_LOOPS{loop_status_pkg::WORD_RST}}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // word and its bits as separate flags
  assign loop_status_word = s_r.word;
  generate
    for (g = 0; g < NUM_LOOPS; g++) begin : g_out
      assign first_alarm_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_ALARM1];
      assign second_alarm_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_ALARM2];
      assign heater_burnout_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_BURNOUT];
      assign autotune_running_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_AUTOTUNE];
      assign output_on_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_OUTPUT];
      assign control_halted_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_HALTED];
      assign invalid_setting_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_BADSET];
      assign tuned_gains_ready_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_GAINS];
      assign awaiting_refresh_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_STANDBY];
      assign cold_junction_fault_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_CJ_FAULT];
      assign heater_current_overrange_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_CT_OVER];
      assign input_sensor_fault_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_SENSOR];
      assign store_done_flag[g] = s_r.word[g*16 + loop_status_pkg::BIT_STORED];
    end
  endgenerate

  assign host_gains_load = host_gains_valid & ~s_r.gains;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // unused bits zero
  unused_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    (loop_status_word[7:5] == 3'b000) && (loop_status_word[23:21] == 3'b000))
    else $error("unassigned status bits set");

  output_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 output_on_flag[0] == $past(control_output[0]))
    else $error("output flag does not follow control output");

  halted_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 control_halted_flag[0] == $past(control_stopped[0]))
    else $error("halted flag does not follow control state");

  autotune_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(autotuning[0]) |=> !autotune_running_flag[0])
    else $error("autotune flag stays after tuning ends");

  gains_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    autotune_gains_update[0] |=> ##1 tuned_gains_ready_flag[0])
    else $error("gains ready not raised after update");

  gains_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.gains[0] |-> !host_gains_load[0])
    else $error("host gains loaded while tuned gains ready");

  gains_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    !s_r.gains[0] && host_gains_valid[0] |-> host_gains_load[0])
    else $error("host gains not loaded while gains clear");

  standby_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    io_refresh |=> ##1 !awaiting_refresh_flag[0] [*2])
    else $error("standby flag stays after refresh");

  ct_over_a: assert property (@(posedge clk) disable iff (!rst_n)
    heater_current[15:0] > loop_status_pkg::CT_LIMIT_DA |=> heater_current_overrange_flag[0])
    else $error("overrange flag missing above 55.0 A");

  burnout_a: assert property (@(posedge clk) disable iff (!rst_n)
    heater_current[15:0] <= burnout_threshold[15:0] |=> heater_burnout_flag[0])
    else $error("burnout flag missing at low current");

  burnout_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    heater_current[15:0] > burnout_threshold[15:0] |=> !heater_burnout_flag[0])
    else $error("burnout flag set at high current");

  ct_under_a: assert property (@(posedge clk) disable iff (!rst_n)
    heater_current[15:0] <= loop_status_pkg::CT_LIMIT_DA |=> !heater_current_overrange_flag[0])
    else $error("overrange flag set within limit");

  alarm1_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 first_alarm_flag[0] == $past((temp_meas[15:0] >= alarm1_lo[15:0]) &&
      (temp_meas[15:0] <= alarm1_hi[15:0])))
    else $error("first alarm flag does not follow range");

  alarm2_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 second_alarm_flag[0] == $past((temp_meas[15:0] >= alarm2_lo[15:0]) &&
      (temp_meas[15:0] <= alarm2_hi[15:0])))
    else $error("second alarm flag does not follow range");

  badset_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 invalid_setting_flag[0] == $past(setting_invalid[0]))
    else $error("setting flag does not follow validity");

  // pin to flag: two sync flops, then the word register
  sequence cj_lag_s;
    ##3 cold_junction_fault_flag[0];
  endsequence

  sequence sensor_lag_s;
    ##3 input_sensor_fault_flag[0];
  endsequence

  cj_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    cold_junction_fault_pin[0] |-> cj_lag_s)
    else $error("cold junction flag missing");

  sensor_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    sensor_open_pin[0] || input_over_range_pin[0] |-> sensor_lag_s)
    else $error("sensor fault flag missing");

  sensor_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    !sensor_open_pin[0] && !input_over_range_pin[0] |-> ##3 !input_sensor_fault_flag[0])
    else $error("sensor fault flag stays");

  store_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    !store_request_bit[0] |-> ##2 !store_done_flag[0])
    else $error("store done flag set without request");

  standby_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    awaiting_refresh_flag[0] && !$past(io_refresh) |=> awaiting_refresh_flag[0])
    else $error("standby flag dropped without refresh");

endmodule

// ---- pkg/loop_flags_if.sv ----
/*
  Carrier for the per-loop store request, write and done flags between the bank top
  and the per-loop store sequencer.  Assumes one clock domain.
*/
`timescale 1ns/100ps
interface loop_flags_if;
  logic store_request_bit;
  logic store_write_done;
  logic store_write_start;
  logic store_done_flag;
  modport top (output store_request_bit, output store_write_done,
               input store_write_start, input store_done_flag);
  modport seq (input store_request_bit, input store_write_done,
               output store_write_start, output store_done_flag);
endinterface

// ---- pkg/loop_status_pkg.sv ----
/*
  Shared constants for the two-loop status flag bank: bit positions
  of the loop status word, widths, reset values and limits.
  Assumes nothing of its surroundings; holds definitions only.
*/
package loop_status_pkg;

  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_LOOPS = 2;
  localparam int unsigned BIT_ALARM1 = 0;
  localparam int unsigned BIT_ALARM2 = 1;
  localparam int unsigned BIT_BURNOUT = 2;
  localparam int unsigned BIT_AUTOTUNE = 3;
  localparam int unsigned BIT_OUTPUT = 4;
  localparam int unsigned BIT_HALTED = 8;
  localparam int unsigned BIT_BADSET = 9;
  localparam int unsigned BIT_GAINS = 10;
  localparam int unsigned BIT_STANDBY = 11;
  localparam int unsigned BIT_CJ_FAULT = 12;
  localparam int unsigned BIT_CT_OVER = 13;
  localparam int unsigned BIT_SENSOR = 14;
  localparam int unsigned BIT_STORED = 15;

  // ------------------------------------------------------------
  // measurement widths and limits
  // ------------------------------------------------------------
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned CUR_W = 16;
  // heater current in tenths of an ampere: 55.0 A
  localparam logic [15:0] CT_LIMIT_DA = 16'h0226;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] WORD_RST = 16'h0800;
  localparam logic STANDBY_RST = 1'b1;
  localparam logic STORED_RST = 1'b0;

  // store sequence states, gray coded along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } store_state_e;

endpackage

// ---- tb/nvm_model.sv ----
/*
  Behavioural model of the non-volatile store behind each loop:
  a write strobe starts a write that finishes after a per-loop delay.
  Assumes the bank's clock and reset, and one-cycle write strobes.
*/
`timescale 1ns/100ps
module nvm_model #(
  parameter int unsigned DELAY0 = 2,
  parameter int unsigned DELAY1 = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write strobe in, completion pulse out
  input wire logic [1:0] store_write_start,
  output logic [1:0] store_write_done
);
  int cnt [2];

  // ----------------------------------------------------------
  // write timing
  // ----------------------------------------------------------
  // write completes later
  // loops differ so one answers promptly and one slowly
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt[0] <= 0;
      cnt[1] <= 0;
      store_write_done <= 2'h0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        store_write_done[g] <= !store_write_start[g] && (cnt[g] == 1);
        if (store_write_start[g]) begin
          cnt[g] <= (g == 0) ? DELAY0 : DELAY1;
        end else if (cnt[g] > 0) begin
          cnt[g] <= cnt[g] - 1;
        end
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the two-loop status bank: drives each
  condition per loop and compares words and flags.
  Assumes the store model in nvm_model.sv and a 10 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, io_refresh;
  logic [1:0] store_request_bit, change_gains_cmd, host_gains_valid;
  logic [31:0] temp_meas, alarm1_lo, alarm1_hi, alarm2_lo, alarm2_hi;
  logic [31:0] heater_current, burnout_threshold, loop_status_word;
  logic [1:0] autotuning, autotune_gains_update, control_output, control_stopped;
  logic [1:0] setting_invalid, store_write_done, cold_junction_fault_pin;
  logic [1:0] sensor_open_pin, input_over_range_pin, store_write_start, host_gains_load;
  logic [1:0] first_alarm_flag, second_alarm_flag, heater_burnout_flag;
  logic [1:0] autotune_running_flag, output_on_flag, control_halted_flag;
  logic [1:0] invalid_setting_flag, tuned_gains_ready_flag, awaiting_refresh_flag;
  logic [1:0] cold_junction_fault_flag, heater_current_overrange_flag;
  logic [1:0] input_sensor_fault_flag, store_done_flag;
  int miscompares, checks_done, n;
  int codes [11] = '{0, 1, 2, 3, 4, 8, 9, 13, 12, 14, 16};

  temp_loop_status_flags dut (.clk(clk), .rst_n(rst_n), .io_refresh(io_refresh),
    .store_request_bit(store_request_bit), .change_gains_cmd(change_gains_cmd),
    .host_gains_valid(host_gains_valid), .temp_meas(temp_meas), .alarm1_lo(alarm1_lo),
    .alarm1_hi(alarm1_hi), .alarm2_lo(alarm2_lo), .alarm2_hi(alarm2_hi),
    .heater_current(heater_current), .burnout_threshold(burnout_threshold),
    .autotuning(autotuning), .autotune_gains_update(autotune_gains_update),
    .control_output(control_output), .control_stopped(control_stopped),
    .setting_invalid(setting_invalid), .store_write_done(store_write_done),
    .cold_junction_fault_pin(cold_junction_fault_pin), .sensor_open_pin(sensor_open_pin),
    .input_over_range_pin(input_over_range_pin), .loop_status_word(loop_status_word),
    .first_alarm_flag(first_alarm_flag), .second_alarm_flag(second_alarm_flag),
    .heater_burnout_flag(heater_burnout_flag), .autotune_running_flag(autotune_running_flag),
    .output_on_flag(output_on_flag), .control_halted_flag(control_halted_flag),
    .invalid_setting_flag(invalid_setting_flag), .tuned_gains_ready_flag(tuned_gains_ready_flag),
    .awaiting_refresh_flag(awaiting_refresh_flag),
    .cold_junction_fault_flag(cold_junction_fault_flag),
    .heater_current_overrange_flag(heater_current_overrange_flag),
    .input_sensor_fault_flag(input_sensor_fault_flag), .store_done_flag(store_done_flag),
    .host_gains_load(host_gains_load), .store_write_start(store_write_start));

  nvm_model #(.DELAY0(2), .DELAY1(5)) mem (.clk(clk), .rst_n(rst_n),
    .store_write_start(store_write_start), .store_write_done(store_write_done));

  // ----------------------------------------------------------
  // clock, compares and closing
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chk_bits(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task wrap_up;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // per-bit stimulus
  // ----------------------------------------------------------
  // one condition per code; loop g follows v[g], boundaries on purpose
  task apply(input int k, input logic [1:0] v);
    for (int g = 0; g < 2; g++) begin
      case (k)
        0: begin
          alarm1_lo[g*16+:16] <= v[g] ? 16'h0032 : 16'h0065;
          alarm1_hi[g*16+:16] <= v[g] ? 16'h0064 : 16'h00c8;
        end
        1: begin
          alarm2_lo[g*16+:16] <= v[g] ? 16'h0064 : 16'h0000;
          alarm2_hi[g*16+:16] <= v[g] ? 16'h0064 : 16'h0063;
        end
        2: burnout_threshold[g*16+:16] <= v[g] ? 16'h000a : 16'h0009;
        3: autotuning[g] <= v[g];
        4: control_output[g] <= v[g];
        8: control_stopped[g] <= v[g];
        9: setting_invalid[g] <= v[g];
        12: cold_junction_fault_pin[g] <= v[g];
        13: heater_current[g*16+:16] <= v[g] ? 16'h0227 : 16'h0226;
        14: sensor_open_pin[g] <= v[g];
        default: input_over_range_pin[g] <= v[g];
      endcase
    end
  endtask

  function logic [1:0] flag_of(input int b);
    case (b)
      0: return first_alarm_flag;
      1: return second_alarm_flag;
      2: return heater_burnout_flag;
      3: return autotune_running_flag;
      4: return output_on_flag;
      8: return control_halted_flag;
      9: return invalid_setting_flag;
      12: return cold_junction_fault_flag;
      13: return heater_current_overrange_flag;
      default: return input_sensor_fault_flag;
    endcase
  endfunction

  // fault pins pass a two-flop synchroniser, hence three cycles
  task run_bit(input int k, input logic [1:0] v);
    int b;
    int lat;
    logic [31:0] e;
    b = (k == 16) ? 14 : k;
    lat = (k == 12 || k >= 14) ? 3 : 1;
    e = 32'h0;
    e[b] = v[0];
    e[16+b] = v[1];
    @(posedge clk);
    apply(k, v);
    repeat (lat) @(posedge clk);
    #1;
    chk_word("status word", e, loop_status_word);
    chk_bits("separate flag", v, flag_of(b));
    @(posedge clk);
    apply(k, 2'b00);
    repeat (3) @(posedge clk);
    #1;
    chk_word("cleared word", 32'h0, loop_status_word);
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    io_refresh = 1'b0;
    miscompares = 0;
    checks_done = 0;
    store_request_bit = 2'h0;
    change_gains_cmd = 2'h0;
    host_gains_valid = 2'h3;
    temp_meas = 32'h00640064;
    alarm1_lo = 32'h0;
    alarm1_hi = 32'h0;
    alarm2_lo = 32'h0;
    alarm2_hi = 32'h0;
    heater_current = 32'h000a000a;
    burnout_threshold = 32'h00090009;
    autotuning = 2'h0;
    autotune_gains_update = 2'h0;
    control_output = 2'h0;
    control_stopped = 2'h0;
    setting_invalid = 2'h0;
    cold_junction_fault_pin = 2'h0;
    sensor_open_pin = 2'h0;
    input_over_range_pin = 2'h0;
    repeat (8) @(posedge clk);
    #1;
    chk_word("reset word", 32'h08000800, loop_status_word);
    chk_bits("reset gains load", 2'b11, host_gains_load);
    @(posedge clk);
    rst_n <= 1'b1;
    // standby ends two cycles after the first refresh
    @(posedge clk);
    io_refresh <= 1'b1;
    @(posedge clk);
    io_refresh <= 1'b0;
    #1;
    chk_bits("standby held", 2'b11, awaiting_refresh_flag);
    @(posedge clk);
    #1;
    chk_word("standby dropped", 32'h0, loop_status_word);
    // every flag bit but gains, standby and stored, each loop alone
    for (int i = 0; i < 11; i++) begin
      run_bit(codes[i], 2'b01);
      run_bit(codes[i], 2'b10);
    end
    // tuned gains set, transfer block, clear, set beating clear
    @(posedge clk);
    autotune_gains_update <= 2'b01;
    @(posedge clk);
    autotune_gains_update <= 2'b00;
    #1;
    chk_bits("load while ready", 2'b10, host_gains_load);
    @(posedge clk);
    #1;
    chk_bits("gains ready", 2'b01, tuned_gains_ready_flag);
    @(posedge clk);
    change_gains_cmd <= 2'b01;
    repeat (2) @(posedge clk);
    #1;
    chk_bits("gains cleared", 2'b00, tuned_gains_ready_flag);
    chk_bits("load after clear", 2'b11, host_gains_load);
    @(posedge clk);
    change_gains_cmd <= 2'b00;
    @(posedge clk);
    change_gains_cmd <= 2'b10;
    autotune_gains_update <= 2'b10;
    @(posedge clk);
    autotune_gains_update <= 2'b00;
    @(posedge clk);
    #1;
    chk_bits("update beats clear", 2'b10, tuned_gains_ready_flag);
    chk_bits("load blocked", 2'b01, host_gains_load);
    // save sequence on both loops
    @(posedge clk);
    store_request_bit <= 2'b11;
    #1;
    chk_bits("write start", 2'b11, store_write_start);
    @(posedge clk);
    #1;
    chk_bits("start one pulse", 2'b00, store_write_start);
    chk_bits("done not early", 2'b00, store_done_flag);
    n = 0;
    while (store_done_flag !== 2'b11 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_word("store word", 32'h80008000, loop_status_word & 32'h80008000);
    @(posedge clk);
    store_request_bit <= 2'b00;
    @(posedge clk);
    #1;
    chk_bits("done stands", 2'b11, store_done_flag);
    @(posedge clk);
    #1;
    chk_bits("done cleared", 2'b00, store_done_flag);
    wrap_up;
  end

  // hang guard, far beyond the 180 or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up;
  end
endmodule
